// >>> logic/adc_sequencer.sv
`timescale 1ns/1ps
// Summary of operation
// - Output rate follows line filter, rate field and conversion kind.
// - Line select 11 picks sinc4, continuous up to 1920 sps.
// - Sinc continuous: after reset or a host filter or convert write, first result held back four sample periods.
// - Later continuous results come at the tabulated continuous rate.
// - Select 00: dual notch FIR, 1 to 16 sps single cycle.
// - Select 01: fifty notch FIR, 1.3 to 35.6 sps, 40 continuous.
// - Select 10: sixty notch FIR, same mapping as fifty.
// - Sinc rates 4 to 1920 continuous; single and duty are quarter.
// - 53 command slots; launch by register write or pin rising edge.
// - Slots run in order, each applied as a host register write.
// - Start slot comes from register or pin entry pointer.
// - Stop on power-down command or any host register write other than a launch write.
// - Without power-down, wrap from slot 52 to slot 0 forever.
// - Slots reset to zero, a power-down command that stops.
// - Sequence done raises interrupt when its enable is set.
// - Done flag set on wrap, power-down, or nested launch.
// - Looping sequence clears done flag on reaching the register entry pointer slot again.
// - Nested launch command jumps to its target slot.
// - Convert, calibrate or wait holds the sequencer until done.
// - Read-only pointer shows current slot address and command.
// - Pointer reads 0x00 idle, 0x3A to 0x6E while active.
// - Unipolar straight binary; bipolar offset binary or two's complement.
// - Host write exits sequence, pointer to 0; launch keeps registers.
// - Slot writes targeting 24-bit or slot addresses store zeros.
module adc_sequencer (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic i_pin_launch,
   input wire logic i_op_done,
   input wire logic [23:0] i_raw_code,
   output logic o_op_start,
   output adc_seq_pkg::cmd_t o_op_cmd,
   output logic [23:0] o_code,
   output logic o_irq,
   output logic o_result_valid
);
   import adc_seq_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   filter_cfg_t filter_q;
   ctrl_cfg_t ctrl_q;
   logic [1:0] conv_kind_q;
   logic [5:0] entry_q;
   logic [5:0] pin_entry_q;
   logic pin_cfg_q;
   logic irq_en_q;
   logic done_flag_q;
   logic [15:0] slots_q [NUM_SLOTS];
   seq_state_t state_q;
   logic [5:0] slot_q;
   cmd_t cur_q;
   logic [23:0] code_q;
   logic [15:0] rate_x10;
   logic sinc_sel;
   logic [2:0] settle_q;
   logic valid_q;

   logic acc, wr_acc, slot_hit, host_wr;
   logic [5:0] slot_idx;
   logic [7:0] slot_ofs;
   assign acc = i_psel && i_penable;
   assign wr_acc = acc && i_pwrite;
   assign slot_ofs = i_paddr - OFS_SLOT_BASE;
   assign slot_idx = slot_ofs[7:2];
   assign slot_hit = (i_paddr >= OFS_SLOT_BASE) && (i_paddr <= OFS_SLOT_LAST) &&
                     (i_paddr[1:0] == 2'b00);
   assign host_wr = wr_acc;
   assign o_pready = 1'b1;

   function automatic logic is_known(input logic [7:0] a);
      return (a == OFS_FILTER) || (a == OFS_CTRL) || (a == OFS_CONVERT) ||
             (a == OFS_SEQ_LAUNCH) || (a == OFS_PIN_CFG) || (a == OFS_STATUS) ||
             (a == OFS_UC_PTR) || (a == OFS_OP_DONE) || (a == OFS_RATE_INFO);
   endfunction

   assign o_pslverr = acc && !is_known(i_paddr) && !slot_hit;

   // Slot contents that cannot be run from the buffer collapse to power-down
   function automatic logic [15:0] slot_filter(input logic [15:0] w);
      logic [7:0] a;
      a = w[15:8];
      if ((a >= CMD_WIDE_LO && a <= CMD_WIDE_HI) ||
          (a >= CMD_WIDE24_LO && a <= CMD_WIDE24_HI)) begin
         return SLOT_RESET;
      end
      return w;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Pin launch synchroniser
   logic pin_s1_q, pin_s2_q, pin_s3_q, pin_edge;
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         pin_s1_q <= 1'b0;
         pin_s2_q <= 1'b0;
         pin_s3_q <= 1'b0;
      end else begin
         pin_s1_q <= i_pin_launch;
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
      end
   end
   assign pin_edge = pin_s2_q && !pin_s3_q && pin_cfg_q;

   ////////////////////////////////////////////////////////////////////////
   // Sequencer control decode
   logic seq_active, launch_reg, launch_any, fetch_pd, fetch_jump, fetch_hold;
   logic exec_wr, wrap, set_done;
   logic [5:0] launch_slot;
   assign seq_active = (state_q != ST_IDLE);
   assign launch_reg = wr_acc && (i_paddr == OFS_SEQ_LAUNCH);
   assign launch_any = launch_reg || (pin_edge && !host_wr);
   assign launch_slot = launch_reg ? i_pwdata[5:0] : pin_entry_q;
   assign fetch_pd = (state_q == ST_EXEC) && (cur_q.addr == CMD_POWER_DOWN);
   assign fetch_jump = (state_q == ST_EXEC) && (cur_q.addr == CMD_SEQ_LAUNCH);
   assign fetch_hold = (cur_q.addr == CMD_CONVERT) || (cur_q.addr == CMD_CAL_START) ||
                       (cur_q.addr == CMD_WAIT);
   assign exec_wr = (state_q == ST_EXEC) && !host_wr;
   assign wrap = exec_wr && !fetch_pd && !fetch_jump && (slot_q == SLOT_LAST) &&
                 !fetch_hold;
   assign set_done = exec_wr && (fetch_pd || fetch_jump) ||
                     wrap || ((state_q == ST_WAIT) && i_op_done && !host_wr &&
                     (slot_q == SLOT_LAST));

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         state_q <= ST_IDLE;
         slot_q <= '0;
         cur_q <= '0;
      end else if (host_wr && !launch_reg) begin
         state_q <= ST_IDLE;
      end else if (launch_any) begin
         state_q <= ST_FETCH;
         slot_q <= launch_slot;
      end else begin
         unique case (state_q)
            ST_IDLE: state_q <= ST_IDLE;
            ST_FETCH: begin
               cur_q <= cmd_t'(slots_q[slot_q]);
               state_q <= ST_EXEC;
            end
            ST_EXEC: begin
               if (fetch_pd) begin
                  state_q <= ST_IDLE;
               end else if (fetch_jump) begin
                  slot_q <= cur_q.data[5:0];
                  state_q <= ST_FETCH;
               end else if (fetch_hold) begin
                  state_q <= ST_WAIT;
               end else begin
                  slot_q <= (slot_q == SLOT_LAST) ? '0 : slot_q + 6'd1;
                  state_q <= ST_FETCH;
               end
            end
            ST_WAIT: begin
               if (i_op_done) begin
                  slot_q <= (slot_q == SLOT_LAST) ? '0 : slot_q + 6'd1;
                  state_q <= ST_FETCH;
               end
            end
         endcase
      end
   end

   assign o_op_start = exec_wr && !fetch_pd && !fetch_jump;
   assign o_op_cmd = cur_q;

   ////////////////////////////////////////////////////////////////////////
   // Control registers: host writes and sequencer writes share one path
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         filter_q <= '0;
         ctrl_q <= '0;
         conv_kind_q <= CONV_SINGLE;
         entry_q <= '0;
         pin_entry_q <= '0;
         pin_cfg_q <= 1'b0;
         irq_en_q <= 1'b0;
      end else if (wr_acc) begin
         unique case (i_paddr)
            OFS_FILTER: filter_q <= filter_cfg_t'(i_pwdata[5:0]);
            OFS_CTRL: ctrl_q <= ctrl_cfg_t'(i_pwdata[1:0]);
            OFS_CONVERT: conv_kind_q <= i_pwdata[1:0];
            OFS_SEQ_LAUNCH: entry_q <= i_pwdata[5:0];
            OFS_PIN_CFG: begin
               pin_cfg_q <= i_pwdata[0];
               pin_entry_q <= i_pwdata[13:8];
               irq_en_q <= i_pwdata[16];
            end
            default: ;
         endcase
      end else if (o_op_start) begin
         unique case (cur_q.addr)
            CMD_FILTER: filter_q <= filter_cfg_t'(cur_q.data[5:0]);
            CMD_CTRL: ctrl_q <= ctrl_cfg_t'(cur_q.data[1:0]);
            CMD_CONVERT: conv_kind_q <= cur_q.data[1:0];
            default: ;
         endcase
      end
   end

   // Set wins over a clear in the same cycle
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         done_flag_q <= 1'b0;
      end else if (set_done) begin
         done_flag_q <= 1'b1;
      end else if (launch_any || (exec_wr && slot_q == entry_q && done_flag_q)) begin
         done_flag_q <= 1'b0;
      end else if (wr_acc && i_paddr == OFS_STATUS && i_pwdata[0]) begin
         done_flag_q <= 1'b0;
      end
   end
   assign o_irq = done_flag_q && irq_en_q;

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         for (int k = 0; k < NUM_SLOTS; k++) begin
            slots_q[k] <= SLOT_RESET;
         end
      end else if (wr_acc && slot_hit) begin
         slots_q[slot_idx] <= slot_filter(i_pwdata[15:0]);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Rate lookup and output formatting
   rate_select u_rate (
      .i_cfg(filter_q),
      .i_conv_kind(conv_kind_q),
      .o_rate_x10(rate_x10),
      .o_sinc(sinc_sel)
   );

   // Sinc continuous withholds first results while the filter fills
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         settle_q <= '0;
         valid_q <= 1'b0;
         code_q <= '0;
      end else begin
         valid_q <= 1'b0;
         if (wr_acc && (i_paddr == OFS_CONVERT || i_paddr == OFS_FILTER)) begin
            settle_q <= '0;
         end else if (i_op_done) begin
            if (sinc_sel && conv_kind_q == CONV_CONT &&
                settle_q < 3'(SINC_SETTLE_PERIODS - 1)) begin
               settle_q <= settle_q + 3'd1;
            end else begin
               valid_q <= 1'b1;
               if (ctrl_q.unipolar_select || ctrl_q.format_offset) begin
                  code_q <= i_raw_code;
               end else begin
                  code_q <= {~i_raw_code[23], i_raw_code[22:0]};
               end
            end
         end
      end
   end
   assign o_code = code_q;
   assign o_result_valid = valid_q;

   ////////////////////////////////////////////////////////////////////////
   logic [6:0] uc_addr;
   assign uc_addr = seq_active ? UC_ADDR_BASE + 7'(slot_q) : UC_ADDR_IDLE;

   always_comb begin
      o_prdata = 32'h0000_0000;
      if (acc && !i_pwrite) begin
         if (slot_hit) begin
            o_prdata = {16'h0000, slots_q[slot_idx]};
         end else begin
            unique case (i_paddr)
               OFS_FILTER: o_prdata = {26'h0, filter_q};
               OFS_CTRL: o_prdata = {30'h0, ctrl_q};
               OFS_CONVERT: o_prdata = {30'h0, conv_kind_q};
               OFS_SEQ_LAUNCH: o_prdata = {26'h0, entry_q};
               OFS_PIN_CFG: o_prdata = {15'h0, irq_en_q, 2'h0, pin_entry_q, 7'h0, pin_cfg_q};
               OFS_STATUS: o_prdata = {30'h0, seq_active, done_flag_q};
               OFS_UC_PTR: o_prdata = {8'h0, cur_q, 1'b0, uc_addr};
               OFS_RATE_INFO: o_prdata = {15'h0, sinc_sel, rate_x10};
               default: o_prdata = 32'h0000_0000;
            endcase
         end
      end
   end
endmodule // adc_sequencer

// >>> logic/adc_seq_pkg.sv
package adc_seq_pkg;
   // APB register byte offsets
   localparam logic [7:0] OFS_FILTER = 8'h00;
   localparam logic [7:0] OFS_CTRL = 8'h04;
   localparam logic [7:0] OFS_CONVERT = 8'h08;
   localparam logic [7:0] OFS_SEQ_LAUNCH = 8'h0C;
   localparam logic [7:0] OFS_PIN_CFG = 8'h10;
   localparam logic [7:0] OFS_STATUS = 8'h14;
   localparam logic [7:0] OFS_UC_PTR = 8'h18;
   localparam logic [7:0] OFS_OP_DONE = 8'h1C;
   localparam logic [7:0] OFS_RATE_INFO = 8'h20;
   // Slot window sits just above the registers: all 53 words fit in 8 address bits
   localparam logic [7:0] OFS_SLOT_BASE = 8'h28;
   localparam logic [7:0] OFS_SLOT_LAST = OFS_SLOT_BASE + 8'hD0;
   // Command address space (bits 15:8 of a slot)
   localparam logic [7:0] CMD_POWER_DOWN = 8'h00;
   localparam logic [7:0] CMD_CONVERT = 8'h01;
   localparam logic [7:0] CMD_SEQ_LAUNCH = 8'h04;
   localparam logic [7:0] CMD_CAL_START = 8'h03;
   localparam logic [7:0] CMD_FILTER = 8'h08;
   localparam logic [7:0] CMD_CTRL = 8'h11;
   localparam logic [7:0] CMD_WAIT = 8'h10;
   localparam logic [7:0] CMD_WIDE_LO = 8'h3A;
   localparam logic [7:0] CMD_WIDE_HI = 8'h6E;
   localparam logic [7:0] CMD_WIDE24_LO = 8'h1A;
   localparam logic [7:0] CMD_WIDE24_HI = 8'h39;
   // Slot numbering and pointer addresses
   localparam int NUM_SLOTS = 53;
   localparam logic [5:0] SLOT_LAST = 6'd52;
   localparam logic [6:0] UC_ADDR_BASE = 7'h3A;
   localparam logic [6:0] UC_ADDR_IDLE = 7'h00;
   localparam logic [15:0] SLOT_RESET = 16'h0000;
   // Line rejection codes, conversion kinds and filter constants
   localparam logic [1:0] LINE_DUAL = 2'b00;
   localparam logic [1:0] LINE_FIFTY = 2'b01;
   localparam logic [1:0] LINE_SIXTY = 2'b10;
   localparam logic [1:0] LINE_SINC = 2'b11;
   localparam logic [1:0] CONV_SINGLE = 2'b00;
   localparam logic [1:0] CONV_CONT = 2'b01;
   localparam logic [1:0] CONV_DUTY = 2'b10;
   localparam int SINC_SETTLE_PERIODS = 4;
   localparam real MOD_CLK_MHZ = 2.456;

   typedef struct packed {
      logic [1:0] line_reject_select;
      logic [3:0] rate;
   } filter_cfg_t;

   typedef struct packed {
      logic unipolar_select;
      logic format_offset;
   } ctrl_cfg_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] data;
   } cmd_t;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_FETCH = 4'b0010,
      ST_EXEC = 4'b0100,
      ST_WAIT = 4'b1000
   } seq_state_t;
endpackage

// >>> logic/rate_select.sv
`timescale 1ns/1ps
module rate_select (
   input wire adc_seq_pkg::filter_cfg_t i_cfg,
   input wire logic [1:0] i_conv_kind,
   output logic [15:0] o_rate_x10,
   output logic o_sinc
);
   import adc_seq_pkg::*;

   // Continuous rates in tenths of sps
   function automatic logic [15:0] cont_rate(input logic [1:0] lf, input logic [3:0] r);
      logic [15:0] v;
      v = 16'h0000;
      unique case (lf)
         LINE_DUAL: v = (r == 4'h0) ? 16'd11 : (r == 4'h1) ? 16'd21 :
                        (r == 4'h2) ? 16'd42 : (r == 4'h3) ? 16'd84 : 16'd168;
         LINE_FIFTY, LINE_SIXTY: v = (r == 4'h0) ? 16'd13 : (r == 4'h1) ? 16'd27 :
                        (r == 4'h2) ? 16'd53 : (r == 4'h3) ? 16'd107 :
                        (r == 4'h4) ? 16'd213 : 16'd400;
         LINE_SINC: begin
            unique case (r)
               4'h0: v = 16'd40;
               4'h1: v = 16'd100;
               4'h2: v = 16'd200;
               4'h3: v = 16'd400;
               4'h4: v = 16'd600;
               4'h5: v = 16'd1200;
               4'h6: v = 16'd2400;
               4'h7: v = 16'd4800;
               4'h8: v = 16'd9600;
               default: v = 16'd19200;
            endcase
         end
      endcase
      return v;
   endfunction

   function automatic logic [15:0] single_rate(input logic [1:0] lf, input logic [3:0] r);
      logic [15:0] v;
      v = 16'h0000;
      if (lf == LINE_DUAL) begin
         v = (r == 4'h0) ? 16'd10 : (r == 4'h1) ? 16'd20 : (r == 4'h2) ? 16'd40 :
             (r == 4'h3) ? 16'd80 : 16'd160;
      end else if (lf == LINE_SINC) begin
         v = cont_rate(lf, r) >> 2;
      end else begin
         v = (r == 4'h0) ? 16'd13 : (r == 4'h1) ? 16'd25 : (r == 4'h2) ? 16'd50 :
             (r == 4'h3) ? 16'd100 : (r == 4'h4) ? 16'd200 : 16'd356;
      end
      return v;
   endfunction

   function automatic logic [15:0] duty_rate(input logic [1:0] lf, input logic [3:0] r);
      logic [15:0] v;
      v = 16'h0000;
      if (lf == LINE_SINC) begin
         v = cont_rate(lf, r) >> 2;
      end else if (lf == LINE_DUAL) begin
         v = (r == 4'h0) ? 16'd3 : (r == 4'h1) ? 16'd5 : (r == 4'h2) ? 16'd11 :
             (r == 4'h3) ? 16'd21 : 16'd42;
      end else begin
         v = (r == 4'h0) ? 16'd3 : (r == 4'h1) ? 16'd7 : (r == 4'h2) ? 16'd13 :
             (r == 4'h3) ? 16'd27 : (r == 4'h4) ? 16'd53 : 16'd100;
      end
      return v;
   endfunction

   always_comb begin
      o_sinc = (i_cfg.line_reject_select == LINE_SINC);
      unique case (i_conv_kind)
         CONV_CONT: o_rate_x10 = cont_rate(i_cfg.line_reject_select, i_cfg.rate);
         CONV_DUTY: o_rate_x10 = duty_rate(i_cfg.line_reject_select, i_cfg.rate);
         default: o_rate_x10 = single_rate(i_cfg.line_reject_select, i_cfg.rate);
      endcase
   end
endmodule // rate_select

// >>> sim/op_engine_model.sv
`timescale 1ns/1ps
module op_engine_model (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_op_start,
   input wire adc_seq_pkg::cmd_t i_op_cmd,
   input wire logic [7:0] i_delay,
   output logic o_op_done,
   output logic [23:0] o_raw_code
);
   import adc_seq_pkg::*;
   logic busy_q;
   logic [7:0] cnt_q;
   logic [23:0] raw_q;
   // Raw code only meaningful with the done pulse; inverted otherwise
   assign o_raw_code = o_op_done ? raw_q : ~raw_q;
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         busy_q <= 1'b0;
         cnt_q <= 8'h00;
         o_op_done <= 1'b0;
         raw_q <= 24'h5A3C81;
      end else begin
         o_op_done <= 1'b0;
         if (i_op_start && (i_op_cmd.addr == CMD_CONVERT || i_op_cmd.addr == CMD_CAL_START ||
               i_op_cmd.addr == CMD_WAIT)) begin
            busy_q <= 1'b1;
            cnt_q <= i_delay;
         end else if (busy_q && cnt_q == 8'h00) begin
            busy_q <= 1'b0;
            o_op_done <= 1'b1;
            raw_q <= raw_q + 24'h0B1357;
         end else if (busy_q) begin
            cnt_q <= cnt_q - 8'h01;
         end
      end
   end
endmodule // op_engine_model

// >>> sim/adc_sequencer_assertions.sv
`timescale 1ns/1ps
module adc_sequencer_assertions (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [31:0] o_prdata,
   input wire logic o_pready,
   input wire logic o_pslverr,
   input wire logic o_op_start,
   input wire adc_seq_pkg::cmd_t o_op_cmd,
   input wire logic i_op_done,
   input wire logic [23:0] i_raw_code,
   input wire logic [23:0] o_code,
   input wire logic o_result_valid,
   input wire logic o_irq
);
   import adc_seq_pkg::*;
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   logic wr_take;
   logic [1:0] ctrl_q;
   logic irq_en_q;
   logic pend_q;
   assign wr_take = i_psel && i_penable && i_pwrite && !o_pslverr;
   ////////////////////////////////////////////////////////////////////////////////
   // Shadows of format, irq enable and pending operations
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) ctrl_q <= 2'b00;
      else if (wr_take && i_paddr == OFS_CTRL) ctrl_q <= i_pwdata[1:0];
      else if (o_op_start && o_op_cmd.addr == CMD_CTRL) ctrl_q <= o_op_cmd.data[1:0];
   end
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) irq_en_q <= 1'b0;
      else if (wr_take && i_paddr == OFS_PIN_CFG) irq_en_q <= i_pwdata[16];
   end
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) pend_q <= 1'b0;
      else if (i_op_done || wr_take) pend_q <= 1'b0;
      else if (o_op_start && (o_op_cmd.addr == CMD_CONVERT || o_op_cmd.addr == CMD_CAL_START ||
            o_op_cmd.addr == CMD_WAIT)) pend_q <= 1'b1;
   end
   ////////////////////////////////////////////////////////////////////////////////
   property p_abort;
      wr_take && i_paddr != OFS_SEQ_LAUNCH |=> !o_op_start [*3];
   endproperty
   a_abort: assert property (p_abort) else $error("sequence ran on after host write");
   property p_hold;
      !(pend_q && o_op_start);
   endproperty
   a_hold: assert property (p_hold) else $error("advanced before operation finished");
   property p_no_stop_issue;
      o_op_start |-> o_op_cmd.addr != CMD_POWER_DOWN && o_op_cmd.addr != CMD_SEQ_LAUNCH;
   endproperty
   a_no_stop_issue: assert property (p_no_stop_issue) else $error("stop or jump issued");
   property p_no_wide;
      o_op_start |-> !(o_op_cmd.addr inside {[CMD_WIDE24_LO:CMD_WIDE_HI]});
   endproperty
   a_no_wide: assert property (p_no_wide) else $error("wide or slot command issued");
   property p_fmt;
      o_result_valid |-> $past(i_op_done) &&
         (ctrl_q[1] || o_code == ($past(i_raw_code) ^ {!ctrl_q[0], 23'h000000}));
   endproperty
   a_fmt: assert property (p_fmt) else $error("result code format wrong");
   property p_irq_en;
      o_irq |-> irq_en_q;
   endproperty
   a_irq_en: assert property (p_irq_en) else $error("interrupt while disabled");
   property p_launch_clr;
      wr_take && i_paddr == OFS_SEQ_LAUNCH |=> !o_irq;
   endproperty
   a_launch_clr: assert property (p_launch_clr) else $error("done kept over launch");
   property p_ptr;
      i_psel && i_penable && !i_pwrite && i_paddr == OFS_UC_PTR |->
         o_prdata[6:0] == 7'h00 || o_prdata[6:0] inside {[7'h3A:7'h6E]};
   endproperty
   a_ptr: assert property (p_ptr) else $error("pointer out of range");
   property p_slverr;
      i_psel && i_penable && i_paddr[1:0] == 2'h0 |->
         o_pslverr == ((i_paddr > OFS_RATE_INFO && i_paddr < OFS_SLOT_BASE) ||
         i_paddr > OFS_SLOT_LAST);
   endproperty
   a_slverr: assert property (p_slverr) else $error("slave error wrong");
endmodule // adc_sequencer_assertions
bind adc_sequencer adc_sequencer_assertions chk_u (.i_clk(i_clk), .i_rst(i_rst),
   .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
   .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
   .o_op_start(o_op_start), .o_op_cmd(o_op_cmd), .i_op_done(i_op_done),
   .i_raw_code(i_raw_code), .o_code(o_code), .o_result_valid(o_result_valid), .o_irq(o_irq));

// >>> sim/adc_sequencer_bench.sv
`timescale 1ns/1ps
module adc_sequencer_bench;
   import adc_seq_pkg::*;
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_fail++; \
   $display("ERROR t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
   logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pin = 1'b0;
   logic [7:0] paddr = 8'h00, dly = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rdat;
   logic pready, pslverr, rerr, op_done, op_start, irq, rvalid, pirq;
   logic [23:0] raw, code, lraw, lcode;
   cmd_t op_cmd, lastcmd;
   int n_fail = 0, checked = 0, nops, nres, nirq;
   localparam logic [23:0] RT [15] = '{24'h00000A, 24'h3C00A0, 24'h1100A8, 24'h0E0015,
      24'h40000D, 24'h7D0190, 24'h540164, 24'h9000C8, 24'hBE0064, 24'hC10028,
      24'hE12580, 24'hFD4B00, 24'hFC12C0, 24'hE612C0, 24'hC0000A};
   always #2 clk = ~clk;
   adc_sequencer dut_u (.i_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr), .i_pin_launch(pin), .i_op_done(op_done),
      .i_raw_code(raw), .o_op_start(op_start), .o_op_cmd(op_cmd), .o_code(code),
      .o_irq(irq), .o_result_valid(rvalid));
   op_engine_model eng_u (.i_clk(clk), .i_rst(rst), .i_op_start(op_start), .i_op_cmd(op_cmd),
      .i_delay(dly), .o_op_done(op_done), .o_raw_code(raw));
   ////////////////////////////////////////////////////////////////////////////////
   // Idle edge at the end keeps back-to-back calls from double-driving psel
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d); apb(1'b1, a, d); endtask
   task automatic rd(input logic [7:0] a); apb(1'b0, a, 32'h0); endtask
   task automatic watch(input int n);
      nops = 0; nres = 0; nirq = 0; pirq = irq;
      repeat (n) begin
         @(posedge clk);
         if (op_start === 1'b1) begin nops++; lastcmd = op_cmd; end
         if (op_done === 1'b1) lraw = raw;
         if (rvalid === 1'b1) begin nres++; lcode = code; end
         if (irq === 1'b1 && pirq !== 1'b1) nirq++;
         pirq = irq;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_regs;
      rd(OFS_SLOT_BASE); `CHK(rdat, 32'h0)
      rd(OFS_UC_PTR); `CHK(rdat[6:0], UC_ADDR_IDLE)
      rd(8'h24); `CHK(rerr, 1'b1)
      `CHK(rdat, 32'h0)
      wr(OFS_SLOT_BASE + 8'h04, 32'h3A05); rd(OFS_SLOT_BASE + 8'h04); `CHK(rdat, 32'h0)
      wr(OFS_SLOT_BASE + 8'h04, 32'h1A05); rd(OFS_SLOT_BASE + 8'h04); `CHK(rdat, 32'h0)
      wr(OFS_SLOT_BASE + 8'h04, 32'h0E21); rd(OFS_SLOT_BASE + 8'h04); `CHK(rdat, 32'h0E21)
      wr(OFS_SLOT_BASE + 8'h04, 32'h0);
      wr(OFS_SEQ_LAUNCH, 32'h0); watch(10); `CHK(nops, 0)
      rd(OFS_STATUS); `CHK(rdat[1:0], 2'h1)
      `CHK(irq, 1'b0)
   endtask
   task automatic t_rates;
      foreach (RT[i]) begin
         wr(OFS_FILTER, {26'h0, RT[i][23:18]});
         wr(OFS_CONVERT, {30'h0, RT[i][17:16]});
         rd(OFS_RATE_INFO); `CHK(rdat[16:0], {RT[i][23:22] == 2'h3, RT[i][15:0]})
      end
   endtask
   task automatic t_format;
      wr(OFS_SLOT_BASE, 32'h0100);
      for (int f = 0; f < 2; f++) begin
         dly <= f ? 8'h14 : 8'h00;
         wr(OFS_CTRL, f);
         wr(OFS_FILTER, 32'h0);
         wr(OFS_SEQ_LAUNCH, 32'h0); watch(60);
         `CHK(nops, 1)
         `CHK(lastcmd, 16'h0100)
         `CHK(nres, 1)
         `CHK(lcode, f ? lraw : lraw ^ 24'h800000)
      end
   endtask
   task automatic t_sinc;
      dly <= 8'h05;
      wr(OFS_FILTER, 32'h30);
      for (int s = 0; s < 4; s++) wr(OFS_SLOT_BASE + 8'(4 * s), 32'h0101);
      wr(OFS_SEQ_LAUNCH, 32'h0); watch(200);
      `CHK(nops, 4)
      `CHK(nres, 1)
      `CHK(lcode, lraw)
   endtask
   task automatic t_pin;
      wr(OFS_SLOT_BASE + 8'h14, 32'h1100);
      wr(OFS_PIN_CFG, 32'h0001_0501);
      wr(OFS_STATUS, 32'h1);
      pin <= 1'b1; watch(40);
      `CHK(nops, 1)
      `CHK(lastcmd, 16'h1100)
      `CHK(irq, 1'b1)
      pin <= 1'b0;
      @(posedge clk);
   endtask
   task automatic t_loop;
      wr(OFS_SLOT_BASE + 8'h08, 32'h1100);
      wr(OFS_SLOT_BASE + 8'h0C, 32'h0402);
      wr(OFS_SEQ_LAUNCH, 32'h2); watch(40);
      `CHK(nops > 5, 1'b1)
      `CHK(nirq > 1, 1'b1)
      rd(OFS_UC_PTR); `CHK(rdat[6:0] inside {7'h3C, 7'h3D}, 1'b1)
      wr(OFS_CTRL, 32'h0); watch(10); `CHK(nops, 0)
      rd(OFS_UC_PTR); `CHK(rdat[6:0], UC_ADDR_IDLE)
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic end_of_test;
      if (n_fail == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_regs();
      t_rates();
      t_format();
      t_sinc();
      t_pin();
      t_loop();
      end_of_test();
   end
   // Tests need under 700 cycles; about thirty times that means a hang
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      end_of_test();
   end
endmodule // adc_sequencer_bench
